// ==== core/erb_defines.svh ====
// Constants for the embedded RAM block family
`ifndef ERB_DEFINES_SVH
`define ERB_DEFINES_SVH

`define ERB_SMALL_W   18
`define ERB_SMALL_D   32
`define ERB_MEDIUM_W  36
`define ERB_MEDIUM_D  128
`define ERB_LARGE_W   144
`define ERB_LARGE_D   4096
`define ERB_MAXW      144
`define ERB_ADDRW     16
`define ERB_WSELW     3
`define ERB_WSEL_MAX  4
`define ERB_UNDEF_BIT 1'b1

`endif

// ==== core/erb_pkg.sv ====
// Types and size helpers for the embedded RAM block family
`include "erb_defines.svh"

package erb_pkg;

    typedef enum logic [1:0] {
        ERB_SMALL,
        ERB_MEDIUM,
        ERB_LARGE
    } erb_kind_e;

    typedef enum logic [2:0] {
        ERB_SINGLE,
        ERB_SIMPLE,
        ERB_TRUE,
        ERB_ROM,
        ERB_SPLIT
    } erb_mode_e;

    typedef struct packed {
        logic                    wr;
        logic                    rd;
        logic [`ERB_ADDRW-1:0]   addr;
        logic [`ERB_MAXW-1:0]    wdata;
    } erb_req_s;

    typedef struct packed {
        erb_mode_e               mode;
        logic                    out_reg_a;
        logic                    out_reg_b;
        logic                    flow;
        logic                    rdw_old;
        logic [`ERB_WSELW-1:0]   wsel_a;
        logic [`ERB_WSELW-1:0]   wsel_b;
    } erb_cfg_s;

    // Native widths include one parity position per byte
    function automatic int erb_width(input erb_kind_e k);
        case (k)
            ERB_SMALL:  erb_width = `ERB_SMALL_W;
            ERB_MEDIUM: erb_width = `ERB_MEDIUM_W;
            default:    erb_width = `ERB_LARGE_W;
        endcase
    endfunction

    function automatic int erb_depth(input erb_kind_e k);
        case (k)
            ERB_SMALL:  erb_depth = `ERB_SMALL_D;
            ERB_MEDIUM: erb_depth = `ERB_MEDIUM_D;
            default:    erb_depth = `ERB_LARGE_D;
        endcase
    endfunction

    // Modes a size cannot offer fall back to the nearest one it can
    function automatic erb_mode_e erb_legal_mode(input erb_kind_e k, input erb_mode_e m);
        erb_legal_mode = m;
        if (m == ERB_TRUE && k == ERB_SMALL) erb_legal_mode = ERB_SIMPLE;
        if (m == ERB_SPLIT && k != ERB_MEDIUM) erb_legal_mode = ERB_SINGLE;
        if (m == ERB_ROM && k == ERB_LARGE) erb_legal_mode = ERB_TRUE;
    endfunction

endpackage : erb_pkg

// ==== core/erb_ram.sv ====
// Embedded synchronous RAM block, one size chosen by parameter
`include "erb_defines.svh"

module erb_ram #(
    parameter erb_pkg::erb_kind_e KIND = erb_pkg::ERB_MEDIUM
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    // Asynchronous clears, active high
    input  wire logic                  i_in_clr,
    input  wire logic                  i_out_clr,
    // Static configuration
    input  wire erb_pkg::erb_cfg_s     i_cfg,
    // Port requests
    input  wire erb_pkg::erb_req_s     i_req_a,
    input  wire erb_pkg::erb_req_s     i_req_b,
    // Read data
    output logic [`ERB_MAXW-1:0]       o_q_a,
    output logic [`ERB_MAXW-1:0]       o_q_b
);
    import erb_pkg::*;

    localparam int W        = erb_width(KIND);
    localparam int D        = erb_depth(KIND);
    localparam int AW       = $clog2(D);
    localparam bit IS_LARGE = (KIND == ERB_LARGE);

    logic [W-1:0]            mem [D];

    erb_mode_e               mode;
    erb_req_s                req     [2];
    logic [`ERB_WSELW-1:0]   ws      [2];
    logic [1:0]              wr_ok;
    logic [1:0]              rd_ok;
    logic [1:0]              rd_go;
    logic                    one_port;
    logic                    split;
    logic                    flow_b;
    logic                    in_rstn;
    logic                    out_rstn;

    logic [1:0]              wr_ff;
    logic [1:0]              nxt_wr;
    logic [`ERB_ADDRW-1:0]   wa_ff   [2];
    logic [`ERB_ADDRW-1:0]   nxt_wa  [2];
    logic [`ERB_MAXW-1:0]    wd_ff   [2];
    logic [`ERB_MAXW-1:0]    nxt_wd  [2];
    logic [`ERB_ADDRW-1:0]   ra_ff   [2];
    logic [`ERB_ADDRW-1:0]   nxt_ra  [2];
    logic [`ERB_ADDRW-1:0]   rn_ff;
    logic [`ERB_ADDRW-1:0]   nxt_rn;
    logic [W-1:0]            q_ff    [2];
    logic [W-1:0]            nxt_q   [2];

    logic [`ERB_ADDRW-1:0]   ra_use  [2];
    logic [AW-1:0]           widx    [2];
    logic [AW-1:0]           ridx    [2];
    logic [W-1:0]            wmask   [2];
    logic [W-1:0]            wdat    [2];
    logic [W-1:0]            dout    [2];
    logic [1:0]              coll;

    // Lane width of a port: native width divided by two to the select
    function automatic int lane_w(input logic [`ERB_WSELW-1:0] sel);
        lane_w = W >> sel;
    endfunction

    function automatic int lane_pos(input logic [`ERB_ADDRW-1:0] addr,
                                    input logic [`ERB_WSELW-1:0] sel);
        logic [`ERB_ADDRW-1:0] low;
        low      = addr & ((16'h0001 << sel) - 16'h0001);
        lane_pos = int'(low) * lane_w(sel);
    endfunction

    function automatic logic [W-1:0] lane_ones(input logic [`ERB_WSELW-1:0] sel);
        lane_ones = (W'(1) << lane_w(sel)) - W'(1);
    endfunction

    function automatic logic [AW-1:0] word_of(input logic [`ERB_ADDRW-1:0] addr,
                                              input logic [`ERB_WSELW-1:0] sel,
                                              input logic                  half,
                                              input logic                  hi);
        logic [`ERB_ADDRW-1:0] w;
        w       = addr >> sel;
        word_of = w[AW-1:0];
        if (half) begin
            word_of[AW-1] = hi;
        end
    endfunction

    // Large block clears its output side only
    assign in_rstn  = i_rstn & ~(i_in_clr & ~IS_LARGE);
    assign out_rstn = i_rstn & ~i_out_clr;

    assign mode   = erb_legal_mode(KIND, i_cfg.mode);
    assign req[0] = i_req_a;
    assign req[1] = i_req_b;
    assign ws[0]  = i_cfg.wsel_a;
    assign ws[1]  = i_cfg.wsel_b;
    assign flow_b = i_cfg.flow & (mode == ERB_SIMPLE) & ~IS_LARGE;

    // Input register next values
    always_comb begin
        one_port = (mode == ERB_SINGLE) || (mode == ERB_SPLIT);
        split    = (mode == ERB_SPLIT);
        // Port A writes in all but ROM; port B only where it owns a write path
        wr_ok[0] = (mode != ERB_ROM);
        wr_ok[1] = (mode == ERB_TRUE) || split;
        rd_ok[0] = (mode != ERB_SIMPLE);
        rd_ok[1] = (mode != ERB_SINGLE);
        for (int p = 0; p < 2; p++) begin
            nxt_wr[p] = req[p].wr & wr_ok[p];
            // Write wins when a single-port user asks for both
            rd_go[p]  = req[p].rd & rd_ok[p] & ~(one_port & req[p].wr);
            nxt_wa[p] = nxt_wr[p] ? req[p].addr : wa_ff[p];
            nxt_wd[p] = nxt_wr[p] ? req[p].wdata : wd_ff[p];
            nxt_ra[p] = rd_go[p] ? req[p].addr : ra_ff[p];
        end
        nxt_rn = rd_go[1] ? req[1].addr : rn_ff;
    end

    always_ff @(posedge i_clk or negedge in_rstn) begin
        if (!in_rstn) begin
            wr_ff <= '0;
            wa_ff <= '{default: '0};
            wd_ff <= '{default: '0};
            ra_ff <= '{default: '0};
        end else begin
            wr_ff <= nxt_wr;
            wa_ff <= nxt_wa;
            wd_ff <= nxt_wd;
            ra_ff <= nxt_ra;
        end
    end

    // Falling-edge read address gives a half-cycle flow-through read
    always_ff @(negedge i_clk or negedge in_rstn) begin
        if (!in_rstn) begin
            rn_ff <= '0;
        end else begin
            rn_ff <= nxt_rn;
        end
    end

    // Array access and read-during-write handling
    always_comb begin
        ra_use[0] = ra_ff[0];
        ra_use[1] = flow_b ? rn_ff : ra_ff[1];
        for (int p = 0; p < 2; p++) begin
            widx[p]  = word_of(wa_ff[p], ws[p], split, p[0]);
            ridx[p]  = word_of(ra_use[p], ws[p], split, p[0]);
            wmask[p] = lane_ones(ws[p]) << lane_pos(wa_ff[p], ws[p]);
            wdat[p]  = (wd_ff[p][W-1:0] << lane_pos(wa_ff[p], ws[p])) & wmask[p];
        end
        for (int p = 0; p < 2; p++) begin
            // Pending write lands at the next edge, so the array still holds old data
            coll[p] = wr_ff[1-p] && (widx[1-p] == ridx[p]);
            if (coll[p] && (IS_LARGE || !i_cfg.rdw_old)) begin
                dout[p] = {W{`ERB_UNDEF_BIT}};
            end else begin
                dout[p] = (mem[ridx[p]] >> lane_pos(ra_use[p], ws[p])) & lane_ones(ws[p]);
            end
            nxt_q[p] = dout[p];
        end
    end

    // Self-timed write: registered request commits on the following edge
    always_ff @(posedge i_clk) begin
        for (int p = 0; p < 2; p++) begin
            if (wr_ff[p]) begin
                mem[widx[p]] <= (mem[widx[p]] & ~wmask[p]) | wdat[p];
            end
        end
    end

    always_ff @(posedge i_clk or negedge out_rstn) begin
        if (!out_rstn) begin
            q_ff <= '{default: '0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Flow-through forces the bypass on port B
    assign o_q_a = `ERB_MAXW'(i_cfg.out_reg_a ? q_ff[0] : dout[0]);
    assign o_q_b = `ERB_MAXW'((i_cfg.out_reg_b && !flow_b) ? q_ff[1] : dout[1]);

    property p_inreg_capture;
        @(posedge i_clk) disable iff (!in_rstn)
            (i_req_a.wr && mode != ERB_ROM) |=> wr_ff[0];
    endproperty
    a_inreg_capture: assert property (p_inreg_capture) else $error("write not registered");

    property p_single_excl;
        @(posedge i_clk) disable iff (!in_rstn)
            (mode == ERB_SINGLE && i_req_a.wr && i_req_a.rd) |=> $stable(ra_ff[0]);
    endproperty
    a_single_excl: assert property (p_single_excl) else $error("read taken with write");

    property p_true_two_writes;
        @(posedge i_clk) disable iff (!in_rstn)
            (mode == ERB_TRUE && i_req_a.wr && i_req_b.wr) |=> (wr_ff == 2'h3);
    endproperty
    a_true_two_writes: assert property (p_true_two_writes) else $error("dual write lost");

    property p_rom_nowrite;
        @(posedge i_clk) disable iff (!in_rstn)
            (mode == ERB_ROM) |=> (wr_ff == 2'h0);
    endproperty
    a_rom_nowrite: assert property (p_rom_nowrite) else $error("write in ROM mode");

    property p_outreg_delay;
        @(posedge i_clk) disable iff (!out_rstn)
            // Edge right after an output clear still shows the cleared register
            (i_cfg.out_reg_a && $stable(i_cfg.out_reg_a) && $past(out_rstn))
                |-> o_q_a == `ERB_MAXW'($past(dout[0]));
    endproperty
    a_outreg_delay: assert property (p_outreg_delay) else $error("output register late");

    property p_flow_bypass;
        @(posedge i_clk) disable iff (!i_rstn)
            flow_b |-> o_q_b == `ERB_MAXW'(dout[1]);
    endproperty
    a_flow_bypass: assert property (p_flow_bypass) else $error("flow-through registered");

    property p_split_half;
        @(posedge i_clk) disable iff (!in_rstn)
            (split && wr_ff[1]) |-> widx[1][AW-1] && !ridx[0][AW-1];
    endproperty
    a_split_half: assert property (p_split_half) else $error("split halves overlap");

    property p_in_clear;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_in_clr && !IS_LARGE) |-> (wr_ff == 2'h0) && (ra_ff[0] == '0);
    endproperty
    a_in_clear: assert property (p_in_clear) else $error("input clear ignored");

    property p_out_clear;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_out_clr && i_cfg.out_reg_a) |-> (o_q_a == '0);
    endproperty
    a_out_clear: assert property (p_out_clear) else $error("output clear late");

    property p_large_rdw;
        @(posedge i_clk) disable iff (!in_rstn)
            (IS_LARGE && coll[1]) |-> (dout[1] == {W{`ERB_UNDEF_BIT}});
    endproperty
    a_large_rdw: assert property (p_large_rdw) else $error("collision not undefined");

endmodule // erb_ram

// ==== tb/erb_user.sv ====
// User-logic model that drives both request ports of the RAM block
`include "erb_defines.svh"

module erb_user (
    // Clock
    input  wire logic              i_clk,
    // Requests towards the block
    output erb_pkg::erb_req_s      o_req_a,
    output erb_pkg::erb_req_s      o_req_b
);
    timeunit 1ns;
    timeprecision 1ps;
    import erb_pkg::*;

    initial begin
        o_req_a = '0;
        o_req_b = '0;
    end

    // Launched after a falling edge, held through the next rising edge
    task automatic drive(input erb_req_s a, input erb_req_s b);
        erb_req_s a_ok;
        a_ok    = a;
        a_ok.rd = a.rd & ~a.wr;
        @(negedge i_clk);
        o_req_a <= a_ok;
        o_req_b <= b;
    endtask

    // Released data is scrambled so stale values never look valid
    task automatic idle();
        erb_req_s a_rel;
        erb_req_s b_rel;
        @(negedge i_clk);
        a_rel       = o_req_a;
        b_rel       = o_req_b;
        a_rel.wr    = 1'b0;
        a_rel.rd    = 1'b0;
        a_rel.wdata = ~a_rel.wdata;
        b_rel.wr    = 1'b0;
        b_rel.rd    = 1'b0;
        b_rel.wdata = ~b_rel.wdata;
        o_req_a <= a_rel;
        o_req_b <= b_rel;
    endtask
endmodule // erb_user

// ==== tb/erb_ram_tb.sv ====
// Self-checking testbench for the medium embedded RAM block
`include "erb_defines.svh"

module erb_ram_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import erb_pkg::*;

    logic                  clk;
    logic                  rstn;
    logic                  in_clr;
    logic                  out_clr;
    erb_cfg_s              cfg;
    erb_req_s              req_a;
    erb_req_s              req_b;
    logic [`ERB_MAXW-1:0]  q_a;
    logic [`ERB_MAXW-1:0]  q_b;
    int                    fail_count;
    int                    checks_done;

    localparam logic [`ERB_MAXW-1:0] D1 = 144'h9_A5C3_1E7B;
    localparam logic [`ERB_MAXW-1:0] D2 = 144'h6_3C96_E184;

    erb_ram #(.KIND(ERB_MEDIUM)) i_erb_ram (
        .i_clk     (clk),
        .i_rstn    (rstn),
        .i_in_clr  (in_clr),
        .i_out_clr (out_clr),
        .i_cfg     (cfg),
        .i_req_a   (req_a),
        .i_req_b   (req_b),
        .o_q_a     (q_a),
        .o_q_b     (q_b)
    );

    erb_user i_erb_user (
        .i_clk   (clk),
        .o_req_a (req_a),
        .o_req_b (req_b)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic erb_req_s rq(input logic wr, input logic rd, input int addr,
                                    input logic [`ERB_MAXW-1:0] d);
        rq = '0;
        rq.wr = wr;
        rq.rd = rd;
        rq.addr = addr[`ERB_ADDRW-1:0];
        rq.wdata = d;
    endfunction

    task automatic chk(input logic [`ERB_MAXW-1:0] seen, input logic [`ERB_MAXW-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic set_cfg(input erb_mode_e m, input logic ra, input logic rb,
                           input logic [`ERB_WSELW-1:0] wa);
        @(negedge clk);
        cfg <= '{mode: m, out_reg_a: ra, out_reg_b: rb, flow: 1'b0, rdw_old: 1'b1,
                 wsel_a: wa, wsel_b: '0};
    endtask

    // Write then read on one port, bypassed and registered output
    task automatic sc_single();
        set_cfg(ERB_SINGLE, 1'b0, 1'b0, '0);
        i_erb_user.drive(rq(1, 0, 5, D1), '0);
        i_erb_user.drive(rq(0, 1, 5, '0), '0);
        i_erb_user.idle();
        chk(q_a, D1);
        set_cfg(ERB_SINGLE, 1'b1, 1'b0, '0);
        i_erb_user.drive(rq(1, 0, 6, D2), '0);
        i_erb_user.drive(rq(0, 1, 6, '0), '0);
        i_erb_user.idle();
        @(negedge clk);
        chk(q_a, D2);
    endtask

    // Both ports write, then both read each other's word
    task automatic sc_true();
        set_cfg(ERB_TRUE, 1'b0, 1'b0, '0);
        i_erb_user.drive(rq(1, 0, 10, D1), rq(1, 0, 9, D2));
        i_erb_user.drive(rq(0, 1, 9, '0), rq(0, 1, 10, '0));
        i_erb_user.idle();
        chk(q_a, D2);
        chk(q_b, D1);
    endtask

    // Read of the word being written shows old contents first
    task automatic sc_rdw();
        set_cfg(ERB_SIMPLE, 1'b0, 1'b0, '0);
        i_erb_user.drive(rq(1, 0, 12, D1), '0);
        i_erb_user.drive(rq(1, 0, 12, D2), rq(0, 1, 12, '0));
        i_erb_user.idle();
        chk(q_b, D1);
        @(negedge clk);
        chk(q_b, D2);
    endtask

    // Two 18-bit lane writes read back as one 36-bit word with parity bits
    task automatic sc_width();
        set_cfg(ERB_TRUE, 1'b0, 1'b0, 3'h1);
        i_erb_user.drive(rq(1, 0, 6, 144'h2_B4C1), '0);
        i_erb_user.drive(rq(1, 0, 7, 144'h1_5A3E), '0);
        i_erb_user.drive('0, rq(0, 1, 3, '0));
        i_erb_user.idle();
        chk(q_b, {108'h0, 18'h1_5A3E, 18'h2_B4C1});
    endtask

    // Output clear acts on a registered output at once
    task automatic sc_clr();
        set_cfg(ERB_SINGLE, 1'b1, 1'b0, '0);
        i_erb_user.drive(rq(0, 1, 5, '0), '0);
        i_erb_user.idle();
        @(negedge clk);
        chk(q_a, D1);
        out_clr <= 1'b1;
        #1;
        chk(q_a, '0);
        @(negedge clk);
        out_clr <= 1'b0;
    endtask

    // Flow-through read on the falling edge, then input clear seen after an edge
    task automatic sc_flow();
        @(negedge clk);
        cfg <= '{mode: ERB_SIMPLE, out_reg_a: 1'b0, out_reg_b: 1'b1, flow: 1'b1,
                 rdw_old: 1'b1, wsel_a: '0, wsel_b: '0};
        i_erb_user.drive(rq(1, 0, 0, D2), rq(0, 1, 10, '0));
        i_erb_user.idle();
        #1;
        chk(q_b, D1);
        @(negedge clk);
        in_clr <= 1'b1;
        @(negedge clk);
        chk(q_b, D2);
        in_clr <= 1'b0;
    endtask

    initial begin
        rstn = 1'b0;
        in_clr = 1'b0;
        out_clr = 1'b0;
        cfg = '0;
        fail_count = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rstn <= 1'b1;
        sc_single();
        sc_true();
        sc_rdw();
        sc_width();
        sc_clr();
        sc_flow();
        end_sim();
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        end_sim();
    end
endmodule // erb_ram_tb
